// [logic/cvph_decoder.sv]
`timescale 1ns/10ps
`default_nettype none
// Contract
// R1: identity reads fixed code; writes are commands
// R2: set number write hard-resets and remembers set
// R3: writing 8 repeats last hard reset; with SOUND set, a repeated plain reset restores sound project values
// R4: writing 0 restores plain defaults
// R5: sound units restore sound project values
// R6: ordinary writes still accepted after reset
// R7: bit n weighs two to the n
// R8: version write only loads offset
// R9: ones digit adds 100 to next value
// R10: tens digit adds 100 to next number
// R11: programmer writes target right after offset
// R12: programmer keeps loco stationary
// R13: 110/120 add 100/200 until power loss
// R14: version write 0 cancels offset
// R15: 210/220 offsets survive power loss
// R16: default 28 speed steps, station agrees
// R17: reference 0 automatic, else tenths of volt
// R18: alternative format detected, 14 steps
// R19: operator sequence enters alternative programming
// R20: headlight blinks once per second there
// R21: signal speed variables need station support
// R22: alternative programming starts in short mode
// R23: both digits apply both offsets together
module cvph_decoder #(
  parameter int          BLINK_HALF = cvph_pkg::BLINK_HALF_CYC,
  parameter bit          SOUND      = 1'b0
) (
  input  wire logic  clk_sys,
  input  wire logic  resetn,
  cvph_if.decoder    link,
  output logic       hard_reset_pulse,
  output logic [7:0] reset_set,
  output logic       reset_sound,
  output logic       store_valid,
  output logic [9:0] store_num,
  output logic [7:0] store_data,
  output logic [7:0] speed_steps,
  output logic       ref_auto,
  output logic [7:0] ref_tenths,
  output logic       sig_speed_en,
  output logic       alt_prog_mode,
  output logic       alt_short_mode,
  output logic       headlight_front
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [3:0] s1_reg;
  logic [3:0] s2_reg;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s1_reg <= 4'h0;
      s2_reg <= 4'h0;
    end else begin
      s1_reg <= {link.power_ok, link.alt_format, link.alt_prog_enter, link.sig_speed_sup};
      s2_reg <= s1_reg;
    end
  end
  wire power_s = s2_reg[3];
  wire alt_s   = s2_reg[2];
  wire enter_s = s2_reg[1];
  wire sigs_s  = s2_reg[0];
  // Request strobes come from same-clock logic, so they are read directly.
  wire wr = link.wr_valid;
  wire rd = link.rd_valid;

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0] last_set_reg;
  logic       once_val_reg;
  logic       once_num_reg;
  logic [9:0] vol_ofs_reg;
  logic [9:0] nv_ofs_reg;   // Models nonvolatile cell: cleared only by a write of 0 or by resetn.
  logic [7:0] steps_reg;
  logic [7:0] ref_reg;
  logic       alt_mode_reg;
  logic [31:0] blink_reg;
  logic       lamp_reg;
  logic       hr_reg;
  logic       st_v_reg;
  logic [9:0] st_n_reg;
  logic [7:0] st_d_reg;
  logic       rsp_v_reg;
  logic [7:0] rsp_d_reg;
  logic       snd_reg;
  logic       sig_en_reg;
  logic       ref_auto_reg;
  logic       power_q_reg;

  // Decoding of the pseudo writes.
  wire to_id   = wr & (link.cv_num == cvph_pkg::CV_IDENTITY);
  wire to_ver  = wr & (link.cv_num == cvph_pkg::CV_VERSION);
  wire normal  = wr & ~to_id & ~to_ver;
  wire power_up = power_s & ~power_q_reg; // Power has just come back.
  wire [7:0] d = link.cv_data;
  wire [7:0] rst_sel = (d == cvph_pkg::RESET_REPEAT) ? last_set_reg : d; // R3 R4
  wire [9:0] ofs_num = (once_num_reg ? cvph_pkg::NUM_STEP_100 : 10'h000)
                     + vol_ofs_reg + nv_ofs_reg; // R10 R13 R15 R23
  wire [9:0] eff_num = link.cv_num + ofs_num;
  wire [7:0] eff_dat = d + (once_val_reg ? cvph_pkg::VAL_STEP_100 : 8'h00); // R9 R23
  wire       sig_cv  = (eff_num >= cvph_pkg::CV_SIG_FIRST) & (eff_num <= cvph_pkg::CV_SIG_LAST);
  // Alternative programming: short mode limits numbers and values.
  wire short_ok = ~alt_mode_reg | ((link.cv_num != 10'h000) & (link.cv_num <= 10'(cvph_pkg::SHORT_MAX))
                 & (d <= cvph_pkg::SHORT_MAX)); // R22

  // ****************************************************************
  // Write handling
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      last_set_reg <= 8'h00;
      once_val_reg <= 1'b0;
      once_num_reg <= 1'b0;
      vol_ofs_reg  <= 10'h000;
      nv_ofs_reg   <= 10'h000;
      steps_reg    <= cvph_pkg::SPEED_STEPS_DFLT; // R16
      ref_reg      <= 8'h00;
      ref_auto_reg <= 1'b1;
      hr_reg       <= 1'b0;
      snd_reg      <= 1'b0;
      st_v_reg     <= 1'b0;
      st_n_reg     <= 10'h000;
      st_d_reg     <= 8'h00;
      rsp_v_reg    <= 1'b0;
      rsp_d_reg    <= 8'h00;
    end else begin
      hr_reg    <= to_id; // R1 R2
      st_v_reg  <= normal & short_ok & (~sig_cv | sig_en_reg); // R6 R21
      rsp_v_reg <= wr | rd;
      if (!power_s) begin
        once_val_reg <= 1'b0;
        once_num_reg <= 1'b0;
        vol_ofs_reg  <= 10'h000; // R13
      end
      if (to_id) begin
        last_set_reg <= (d == cvph_pkg::RESET_PLAIN) ? 8'h00 : rst_sel; // R2 R3
        snd_reg      <= SOUND & (d != cvph_pkg::RESET_PLAIN); // R5
        steps_reg    <= cvph_pkg::SPEED_STEPS_DFLT;
        ref_reg      <= 8'h00;
        ref_auto_reg <= 1'b1;
      end
      if (to_ver) begin // R8
        once_val_reg <= d == cvph_pkg::OFS_VAL_ONCE || d == cvph_pkg::OFS_BOTH_ONCE;
        once_num_reg <= d == cvph_pkg::OFS_NUM_ONCE || d == cvph_pkg::OFS_BOTH_ONCE;
        unique case (d)
          cvph_pkg::OFS_CLEAR: begin
            vol_ofs_reg <= 10'h000;
            nv_ofs_reg  <= 10'h000; // R14
          end
          cvph_pkg::OFS_NUM100_VOL: vol_ofs_reg <= cvph_pkg::NUM_STEP_100;
          cvph_pkg::OFS_NUM200_VOL: vol_ofs_reg <= cvph_pkg::NUM_STEP_200;
          cvph_pkg::OFS_NUM100_NV: nv_ofs_reg <= cvph_pkg::NUM_STEP_100; // R15
          cvph_pkg::OFS_NUM200_NV: nv_ofs_reg <= cvph_pkg::NUM_STEP_200;
          default: ;
        endcase
      end else if (normal) begin
        once_val_reg <= 1'b0;
        once_num_reg <= 1'b0;
        st_n_reg     <= eff_num;
        st_d_reg     <= eff_dat; // R7
        if (eff_num == cvph_pkg::CV_REF_VOLTAGE) begin
          ref_reg      <= eff_dat; // R17
          ref_auto_reg <= (eff_dat == 8'h00);
        end
      end
      if (alt_s) steps_reg <= cvph_pkg::ALT_STEPS; // R18
      else if (to_id == 1'b0 && steps_reg == cvph_pkg::ALT_STEPS) steps_reg <= cvph_pkg::SPEED_STEPS_DFLT;
      // Reads: identity and version never show what was written.
      if (link.cv_num == cvph_pkg::CV_IDENTITY) rsp_d_reg <= cvph_pkg::ID_CODE; // R1
      else if (link.cv_num == cvph_pkg::CV_VERSION) rsp_d_reg <= cvph_pkg::VER_DEFAULT; // R8
      else rsp_d_reg <= d;
    end
  end

  // ****************************************************************
  // Alternative-format programming and headlight blink
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      alt_mode_reg <= 1'b0;
      blink_reg    <= 32'h0000_0000;
      lamp_reg     <= 1'b0;
      power_q_reg  <= 1'b0;
    end else begin
      power_q_reg  <= power_s;
      // Entry needs the throttle held while power comes back, not merely held.
      if (!power_s) alt_mode_reg <= 1'b0;
      else if (power_up && alt_s && enter_s) alt_mode_reg <= 1'b1; // R19 R22
      if (!alt_mode_reg) begin
        blink_reg <= 32'h0000_0000;
        lamp_reg  <= 1'b0;
      end else if (blink_reg == 32'(BLINK_HALF - 1)) begin
        blink_reg <= 32'h0000_0000;
        lamp_reg  <= ~lamp_reg; // R20
      end else begin
        blink_reg <= blink_reg + 32'h0000_0001;
      end
    end
  end

  // Signal-controlled speed support is a level from the station, kept registered.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) sig_en_reg <= 1'b0;
    else sig_en_reg <= sigs_s; // R21
  end

  assign hard_reset_pulse = hr_reg;
  assign reset_set        = last_set_reg;
  assign reset_sound      = snd_reg;
  assign store_valid      = st_v_reg;
  assign store_num        = st_n_reg;
  assign store_data       = st_d_reg;
  assign speed_steps      = steps_reg;
  assign ref_auto         = ref_auto_reg; // R17
  assign ref_tenths       = ref_reg;
  assign sig_speed_en     = sig_en_reg;
  assign alt_prog_mode    = alt_mode_reg;
  assign alt_short_mode   = alt_mode_reg;
  assign headlight_front  = lamp_reg;
  assign link.rsp_valid   = rsp_v_reg;
  assign link.rsp_data    = rsp_d_reg;
  assign link.moving      = 1'b0;


endmodule : cvph_decoder
`default_nettype wire

// [logic/cvph_pkg.sv]
`default_nettype none
package cvph_pkg;

  // ****************************************************************
  // Variable numbers and pseudo-write codes
  // ****************************************************************
  localparam logic [9:0] CV_VERSION       = 10'h007;
  localparam logic [9:0] CV_IDENTITY      = 10'h008;
  localparam logic [9:0] CV_REF_VOLTAGE   = 10'h039;
  localparam logic [9:0] CV_SIG_FIRST     = 10'h031;
  localparam logic [9:0] CV_SIG_LAST      = 10'h036;
  localparam logic [7:0] ID_CODE          = 8'h5a;   // Arbitrary identity value.
  localparam logic [7:0] VER_DEFAULT      = 8'h21;
  localparam logic [7:0] RESET_REPEAT     = 8'h08;
  localparam logic [7:0] RESET_PLAIN      = 8'h00;
  localparam logic [7:0] OFS_CLEAR        = 8'h00;
  localparam logic [7:0] OFS_VAL_ONCE     = 8'h01;
  localparam logic [7:0] OFS_NUM_ONCE     = 8'h0a;
  localparam logic [7:0] OFS_BOTH_ONCE    = 8'h0b;
  localparam logic [7:0] OFS_NUM100_VOL   = 8'h6e;
  localparam logic [7:0] OFS_NUM200_VOL   = 8'h78;
  localparam logic [7:0] OFS_NUM100_NV    = 8'hd2;
  localparam logic [7:0] OFS_NUM200_NV    = 8'hdc;
  localparam logic [9:0] NUM_STEP_100     = 10'h064;
  localparam logic [9:0] NUM_STEP_200     = 10'h0c8;
  localparam logic [7:0] VAL_STEP_100     = 8'h64;
  localparam logic [7:0] SHORT_MAX        = 8'h4f;
  localparam logic [7:0] SPEED_STEPS_DFLT = 8'h1c;
  localparam logic [7:0] ALT_STEPS        = 8'h0e;

  // ****************************************************************
  // Timing at 250 MHz
  // ****************************************************************
  localparam int CLK_MHZ      = 250;
  localparam int BLINK_HALF_MS = 500;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;

endpackage : cvph_pkg
`default_nettype wire

// [logic/cvph_if.sv]
`timescale 1ns/10ps
`default_nettype none
// Write/read channel from programmer to decoder plus status pins.
interface cvph_if;
  logic       wr_valid;
  logic       rd_valid;
  logic [9:0] cv_num;
  logic [7:0] cv_data;
  logic       power_ok;
  logic       alt_format;
  logic       alt_prog_enter;
  logic       moving;
  logic       sig_speed_sup;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  modport decoder (input wr_valid, rd_valid, cv_num, cv_data, power_ok, alt_format,
                   alt_prog_enter, sig_speed_sup, output moving, rsp_valid, rsp_data);
  modport station (output wr_valid, rd_valid, cv_num, cv_data, power_ok, alt_format,
                   alt_prog_enter, sig_speed_sup, input moving, rsp_valid, rsp_data);
endinterface : cvph_if
`default_nettype wire

// [logic/cvph_station.sv]
`timescale 1ns/10ps
`default_nettype none
// Programmer end: issues one request per user strobe, waits for the answer.
module cvph_station (
  input  wire logic  clk_sys,
  input  wire logic  resetn,
  cvph_if.station    link,
  input  wire logic  user_wr,
  input  wire logic  user_rd,
  input  wire logic [9:0] user_num,
  input  wire logic [7:0] user_data,
  input  wire logic  user_power,
  input  wire logic  user_alt,
  input  wire logic  user_alt_enter,
  output logic       user_busy,
  output logic       user_done,
  output logic [7:0] user_rdata
);

  logic busy_reg;
  logic wr_reg;
  logic rd_reg;
  logic [9:0] num_reg;
  logic [7:0] data_reg;
  logic done_reg;
  logic [7:0] rdata_reg;
  logic power_reg;
  logic alt_reg;
  logic alt_enter_reg;

  // Requests only while loco stands and power is on; power_ok just follows user_power, even between a one-shot offset and its target.
  wire accept = user_power & ~busy_reg & ~link.moving & (user_wr | user_rd); // R11 R12

  // ****************************************************************
  // Request sequencing
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busy_reg      <= 1'b0;
      wr_reg        <= 1'b0;
      rd_reg        <= 1'b0;
      num_reg       <= 10'h000;
      data_reg      <= 8'h00;
      done_reg      <= 1'b0;
      rdata_reg     <= 8'h00;
      power_reg     <= 1'b0;
      alt_reg       <= 1'b0;
      alt_enter_reg <= 1'b0;
    end else begin
      power_reg     <= user_power;
      alt_reg       <= user_alt;
      alt_enter_reg <= user_alt_enter; // R19
      wr_reg        <= accept & user_wr;
      rd_reg        <= accept & ~user_wr;
      done_reg      <= busy_reg & link.rsp_valid;
      if (accept) begin
        busy_reg <= 1'b1;
        num_reg  <= user_num;
        data_reg <= user_data;
      end else if (link.rsp_valid) begin
        busy_reg  <= 1'b0;
        rdata_reg <= link.rsp_data;
      end
    end
  end

  assign link.wr_valid       = wr_reg;
  assign link.rd_valid       = rd_reg;
  assign link.cv_num         = num_reg;
  assign link.cv_data        = data_reg;
  assign link.power_ok       = power_reg;
  assign link.alt_format     = alt_reg;
  assign link.alt_prog_enter = alt_enter_reg;
  assign link.sig_speed_sup  = 1'b0; // R21
  assign user_busy           = busy_reg;
  assign user_done           = done_reg;
  assign user_rdata          = rdata_reg;

endmodule : cvph_station
`default_nettype wire

// [test/cvph_chk.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Link checker
// ****************************************************************
module cvph_chk (
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic       wr_valid,
  input wire logic       rd_valid,
  input wire logic [9:0] cv_num,
  input wire logic       moving,
  input wire logic       rsp_valid,
  input wire logic [7:0] rsp_data
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Requests and answers pair one to one, one cycle apart.
  rsp_follows_a: assert property ((wr_valid || rd_valid) |=> rsp_valid) else $error("no answer");
  rsp_caused_a: assert property (rsp_valid |-> $past(wr_valid || rd_valid)) else $error("stray answer");
  rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid) else $error("answer too long");
  // Reads of the two pseudo variables always give the fixed values.
  id_read_a: assert property (rd_valid && cv_num == cvph_pkg::CV_IDENTITY
    |=> rsp_data == cvph_pkg::ID_CODE) else $error("identity changed");
  ver_read_a: assert property (rd_valid && cv_num == cvph_pkg::CV_VERSION
    |=> rsp_data == cvph_pkg::VER_DEFAULT) else $error("version changed");
  data_hold_a: assert property (!rsp_valid |-> $stable(rsp_data)) else $error("data moved");
  // The programmer keeps one request open and never mixes kinds.
  one_req_a: assert property ((wr_valid || rd_valid) |=> !(wr_valid || rd_valid) [*2])
    else $error("request too soon");
  excl_req_a: assert property (!(wr_valid && rd_valid)) else $error("read and write");
  still_a: assert property (!moving) else $error("moving while programming");
endmodule : cvph_chk
`default_nettype wire

// [test/config_variable_pseudo_write_handler_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Both ends joined, checked against a small model
// ****************************************************************
module config_variable_pseudo_write_handler_tb_top;
  logic       clk_sys, resetn, user_wr, user_rd, user_power, user_alt, user_alt_enter;
  logic [9:0] user_num, st_num, vol;
  logic [7:0] user_data, st_dat, set_mem, user_rdata, reset_set, store_data, speed_steps;
  logic [7:0] ref_tenths;
  logic [9:0] store_num;
  logic       user_busy, user_done, hard_reset_pulse, reset_sound, store_valid, ref_auto;
  logic       sig_speed_en, alt_prog_mode, alt_short_mode, headlight_front;
  logic       st_seen, hr_seen, on, ov, nv, alt, h;
  int         err_count = 0, samples_checked = 0, n, i;
  int         seed = 32'h942a1723;
  logic [31:0] r;
  logic [7:0] codes [4] = '{8'h01, 8'h0a, 8'h0b, 8'h00};
  localparam int BLINK_TB = 4; // A short blink half period keeps the run brief.
  cvph_if u_cvph_if ();
  cvph_station u_cvph_station (.clk_sys(clk_sys), .resetn(resetn), .link(u_cvph_if),
    .user_wr(user_wr), .user_rd(user_rd), .user_num(user_num), .user_data(user_data),
    .user_power(user_power), .user_alt(user_alt), .user_alt_enter(user_alt_enter),
    .user_busy(user_busy), .user_done(user_done), .user_rdata(user_rdata));
  cvph_decoder #(.BLINK_HALF(BLINK_TB), .SOUND(1'b0)) u_cvph_decoder (.clk_sys(clk_sys),
    .resetn(resetn), .link(u_cvph_if), .hard_reset_pulse(hard_reset_pulse),
    .reset_set(reset_set), .reset_sound(reset_sound), .store_valid(store_valid),
    .store_num(store_num), .store_data(store_data), .speed_steps(speed_steps),
    .ref_auto(ref_auto), .ref_tenths(ref_tenths), .sig_speed_en(sig_speed_en),
    .alt_prog_mode(alt_prog_mode), .alt_short_mode(alt_short_mode),
    .headlight_front(headlight_front));
  cvph_chk u_cvph_chk (.clk_sys(clk_sys), .resetn(resetn), .wr_valid(u_cvph_if.wr_valid),
    .rd_valid(u_cvph_if.rd_valid), .cv_num(u_cvph_if.cv_num), .moving(u_cvph_if.moving),
    .rsp_valid(u_cvph_if.rsp_valid), .rsp_data(u_cvph_if.rsp_data));
  // A 4 ns clock.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Latch stores and resets, since they stand one cycle only.
  always @(posedge clk_sys) begin
    if (store_valid === 1'b1) begin
      st_seen = 1'b1;
      st_num = store_num;
      st_dat = store_data;
    end
    if (hard_reset_pulse === 1'b1) hr_seen = 1'b1;
  end
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize;
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : cyc
  // One request; a bounded wait for done keeps a hang from stalling the run.
  task automatic xfer(input logic w, input logic [9:0] num, input logic [7:0] data);
    st_seen = 1'b0;
    hr_seen = 1'b0;
    {user_wr, user_rd, user_num, user_data} = {w, !w, num, data};
    cyc(1);
    {user_wr, user_rd} = 2'b00;
    for (n = 0; n < 50 && user_done !== 1'b1; n++) cyc(1);
    if (n == 50) begin
      err_count++;
      summarize();
    end
    check(user_busy, 1'b0);
  endtask : xfer
  function automatic logic [9:0] num_ofs(input logic [7:0] d);
    return (d == 8'h6e || d == 8'hd2) ? 10'h064 : (d == 8'h78 || d == 8'hdc) ? 10'h0c8 : 10'h000;
  endfunction : num_ofs
  // Model the effect of one write, then compare what the decoder did.
  task automatic wr(input logic [9:0] num, input logic [7:0] data);
    logic [9:0] en;
    logic [7:0] ed;
    logic       es;
    en = num + vol + (on ? 10'h064 : 10'h000);
    ed = data + (ov ? 8'h64 : 8'h00);
    es = !(alt && (num > 10'd79 || num == 10'd0));
    es = es && !(en >= 10'd49 && en <= 10'd54);
    xfer(1'b1, num, data);
    if (num == cvph_pkg::CV_VERSION) begin
      es = 1'b0;
      if (data == 8'h00 || num_ofs(data) != 10'h000) vol = num_ofs(data);
      nv = data > 8'hc8;
      on = data == 8'h0a || data == 8'h0b;
      ov = data == 8'h01 || data == 8'h0b;
    end else if (num == cvph_pkg::CV_IDENTITY) begin
      es = 1'b0;
      if (data != 8'h08) set_mem = data;
      check(hr_seen, 1'b1);
      check(reset_set, set_mem);
      check(reset_sound, 1'b0);
    end else begin
      {on, ov} = 2'b00;
      if (es) begin
        check(st_num, en);
        check(st_dat, ed);
      end
    end
    check(st_seen, es);
  endtask : wr
  task automatic power_cycle;
    user_power = 1'b0;
    cyc(4);
    user_power = 1'b1;
    cyc(4);
    {on, ov} = 2'b00;
    if (!nv) vol = 10'h000;
  endtask : power_cycle
  initial begin
    {resetn, user_wr, user_rd, user_alt, user_alt_enter, user_num, user_data} = '0;
    {st_seen, hr_seen, on, ov, nv, alt, vol, set_mem, st_num, st_dat} = '0;
    user_power = 1'b1;
    cyc(6);
    resetn = 1'b1;
    cyc(3);
    check(speed_steps, 10'd28);
    xfer(1'b0, cvph_pkg::CV_IDENTITY, 8'h00);
    check(user_rdata, cvph_pkg::ID_CODE);
    wr(8, 12); wr(20, 33); wr(8, 8); wr(8, 0);
    wr(7, 1); wr(5, 60); wr(7, 10); wr(22, 25); wr(7, 11); wr(30, 40);
    xfer(1'b0, cvph_pkg::CV_VERSION, 8'h00);
    check(user_rdata, cvph_pkg::VER_DEFAULT);
    wr(7, 110); wr(166, 45); power_cycle(); wr(166, 45);
    wr(7, 120); wr(66, 45); wr(7, 0); wr(66, 45);
    wr(7, 220); power_cycle(); wr(66, 45); wr(7, 0);
    wr(57, 140);
    check(ref_tenths, 10'd140);
    check(ref_auto, 1'b0);
    wr(57, 0);
    check(ref_auto, 1'b1);
    wr(50, 3);
    check(sig_speed_en, 1'b0);
    for (i = 0; i < 8; i++) wr(9, 8'h01 << i);
    for (i = 0; i < 24; i++) begin
      r = $random(seed);
      if (r[1:0] == 2'b00) wr(7, codes[r[3:2]]);
      else wr(10'd9 + 10'({$random(seed)} % 40), 8'({$random(seed)} % 156));
    end
    // Alternative format, then the programming entry with power dropped.
    user_alt = 1'b1;
    cyc(4);
    check(speed_steps, 10'd14);
    user_alt_enter = 1'b1;
    power_cycle();
    user_alt_enter = 1'b0;
    for (n = 0; n < 100 && alt_prog_mode !== 1'b1; n++) cyc(1);
    check(alt_prog_mode, 1'b1);
    check(alt_short_mode, 1'b1);
    h = headlight_front;
    for (n = 0; n < 20 && headlight_front === h; n++) cyc(1);
    h = headlight_front;
    for (n = 0; n < 20 && headlight_front === h; n++) cyc(1);
    check(10'(n), 10'(BLINK_TB));
    alt = 1'b1;
    wr(80, 5); wr(79, 5);
    summarize();
  end
endmodule : config_variable_pseudo_write_handler_tb_top
`default_nettype wire
